// ### core/ecdc_defs.svh
// Constants for the eight-bit counter/delay configuration block: offsets, fields, reset values, divisors.
// Assumes it is included by its bare name from every design file that needs a figure.
`ifndef ECDC_DEFS_SVH
`define ECDC_DEFS_SVH

// Register byte offsets on the bus; instance n of five sits at CFG_BASE plus four times n.
`define ECDC_OFF_CFG_BASE 8'h00
`define ECDC_OFF_STATUS 8'h14
`define ECDC_OFF_COUNT_LO 8'h18
`define ECDC_OFF_COUNT_HI 8'h1c

// Field positions inside a configuration word.
`define ECDC_LOAD_LSB 0
`define ECDC_CSEL_LSB 8
`define ECDC_EDGE_LSB 12
`define ECDC_FUNC_BIT 14

// Reset values of a configuration word, standing in for the programmed bits.
`define ECDC_LOAD_RST 8'hff
`define ECDC_CSEL_RST 4'h0
`define ECDC_EDGE_RST 2'h0
`define ECDC_FUNC_RST 1'b0

// Divisors of the oscillator taps; the shared divider wraps at their common multiple.
`define ECDC_DIV_A 8'd4
`define ECDC_DIV_B 8'd12
`define ECDC_DIV_C 8'd24
`define ECDC_DIV_D 8'd64
`define ECDC_DIV_WRAP 8'd191
`define ECDC_ROUTE_DIV_LAST 3'h7

// Clock-select codes of the 3-bit selector.
`define ECDC_C3_RC 3'h0
`define ECDC_C3_D4 3'h1
`define ECDC_C3_D24 3'h2
`define ECDC_C3_D64 3'h3
`define ECDC_C3_LF 3'h4
`define ECDC_C3_PREV 3'h5
`define ECDC_C3_RING 3'h6
`define ECDC_C3_ROUTE 3'h7

// Clock-select codes of the 4-bit selector.
`define ECDC_C4_RC 4'h0
`define ECDC_C4_D4 4'h1
`define ECDC_C4_D12 4'h2
`define ECDC_C4_D24 4'h3
`define ECDC_C4_D64 4'h4
`define ECDC_C4_PREV 4'h5
`define ECDC_C4_ROUTE 4'h6
`define ECDC_C4_ROUTE_D8 4'h7
`define ECDC_C4_RING 4'h8
`define ECDC_C4_SPI 4'h9
`define ECDC_C4_LF 4'ha
`define ECDC_C4_FSM256 4'hb
`define ECDC_C4_PWM 4'hc

`endif

// ### core/ecdc_pkg.sv
// Types shared by the counter/delay configuration block.
// Assumes the constants header is available for the files that use these types.
package ecdc_pkg;

  // One instance's configuration, laid out as in its register word.
  typedef struct packed {
    logic func;
    logic [1:0] edge_mode;
    logic [3:0] csel;
    logic [7:0] load;
  } ecdc_cfg_type;

  // One-cycle tick pulses of every shared clock source.
  typedef struct packed {
    logic rc;
    logic rc_d4;
    logic rc_d12;
    logic rc_d24;
    logic rc_d64;
    logic low_freq;
    logic ring;
    logic spi_clk;
    logic fsm_d256;
    logic pulse_mod;
    logic route_a72_d8;
  } ecdc_ticks_type;

  // States of one counter/delay engine.
  typedef enum logic [1:0] {
    ECDC_ST_IDLE = 2'b00,
    ECDC_ST_RUN = 2'b01,
    ECDC_ST_HOLD = 2'b10
  } ecdc_state_type;

  // Codes of the edge or reset-mode field.
  typedef enum logic [1:0] {
    ECDC_EDGE_BOTH = 2'b00,
    ECDC_EDGE_FALL = 2'b01,
    ECDC_EDGE_RISE = 2'b10,
    ECDC_EDGE_NONE = 2'b11
  } ecdc_edge_type;

endpackage

// ### core/ecdc_sync.sv
// Two-flop synchroniser with a rising-edge pulse, for a group of asynchronous inputs.
// Assumes inputs come from outside the clock domain; outputs are on clock.
`timescale 1ns/1ps
module ecdc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Asynchronous inputs.
  input wire logic [W-1:0] din,
  // Synchronised level and one-cycle rising-edge pulse.
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] meta_r, meta_nxt, sync_r, sync_nxt, last_r, last_nxt;

  // Only the second stage reads the first; edges are taken between the second and third.
  always_comb
  begin
    meta_nxt = din;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  // Registers of the chain.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
      last_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;

endmodule

// ### core/ecdc_src_sel.sv
// Clock-source selector of one counter/delay instance, 3-bit or 4-bit code.
// Assumes every source is already a one-cycle tick on the block clock.
`timescale 1ns/1ps
`include "ecdc_defs.svh"
module ecdc_src_sel import ecdc_pkg::*; #(
  parameter bit WIDE = 1'b0
) (
  // Shared tick sources.
  input wire ecdc_ticks_type ticks,
  input wire logic prev_tick,
  input wire logic route_tick,
  // Selection code.
  input wire logic [3:0] csel,
  // Selected tick and reserved-code flag.
  output logic tick,
  output logic reserved
);

  // A reserved code yields no tick at all, so the instance simply stands still.
  always_comb
  begin
    tick = 1'b0;
    reserved = 1'b0;
    if (!WIDE)
    begin
      case (csel[2:0])
        `ECDC_C3_RC: tick = ticks.rc;
        `ECDC_C3_D4: tick = ticks.rc_d4;
        `ECDC_C3_D24: tick = ticks.rc_d24;
        `ECDC_C3_D64: tick = ticks.rc_d64;
        `ECDC_C3_LF: tick = ticks.low_freq;
        `ECDC_C3_PREV: tick = prev_tick;
        `ECDC_C3_RING: tick = ticks.ring;
        `ECDC_C3_ROUTE: tick = route_tick;
        default: tick = 1'b0;
      endcase
    end
    else
    begin
      case (csel)
        `ECDC_C4_RC: tick = ticks.rc;
        `ECDC_C4_D4: tick = ticks.rc_d4;
        `ECDC_C4_D12: tick = ticks.rc_d12;
        `ECDC_C4_D24: tick = ticks.rc_d24;
        `ECDC_C4_D64: tick = ticks.rc_d64;
        `ECDC_C4_PREV: tick = prev_tick;
        `ECDC_C4_ROUTE: tick = route_tick;
        `ECDC_C4_ROUTE_D8: tick = ticks.route_a72_d8;
        `ECDC_C4_RING: tick = ticks.ring;
        `ECDC_C4_SPI: tick = ticks.spi_clk;
        `ECDC_C4_LF: tick = ticks.low_freq;
        `ECDC_C4_FSM256: tick = ticks.fsm_d256;
        `ECDC_C4_PWM: tick = ticks.pulse_mod;
        default: reserved = 1'b1;
      endcase
    end
  end

endmodule

// ### core/ecdc_top.sv
// Five chained 8-bit counter/delay instances with their configuration, reached over AHB-Lite.
// Assumes oscillators, routing signals and triggers arrive asynchronously on pins.
// What this block does
// - Every instance takes its 8-bit count or delay length from its own field.
// - Instances five to seven pick their clock by a 3-bit code.
// - Code 101 or 0101 clocks an instance from the previous instance's done.
// - Instances eight and nine pick their clock by a 4-bit code.
// - Codes 0111, 1011, 1100 give route signal by eight, state clock, modulator clock.
// - Code 1001 clocks the instance from the serial interface clock.
// - Codes 1101 to 1111 are reserved and give no clock.
// - In delay function the edge field picks both, falling, rising or no edge.
// - In counter function the field picks reset on both, falling or rising edges.
// - Counter reset code 11 holds the counter reset while the input is high.
// - Function bit picks delay at 0, counter at 1; instance eight adds ramp.
`timescale 1ns/1ps
`include "ecdc_defs.svh"
module ecdc_top import ecdc_pkg::*; #(
  parameter int N_INST = 5,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Asynchronous clock sources.
  input wire logic rc_osc_clk,
  input wire logic low_freq_osc_clk,
  input wire logic ring_osc_clk,
  input wire logic spi_clk,
  input wire logic state_machine_clk_div_256,
  input wire logic pulse_mod_clk,
  // Routing-matrix signals and the done of the counter before instance five.
  input wire logic route_a_sig_72,
  input wire logic route_a_sig_73,
  input wire logic route_b_sig_73,
  input wire logic prev_count_done,
  // Delay inputs or counter reset inputs, one per instance.
  input wire logic [N_INST-1:0] trig_in,
  // Instance outputs.
  output logic [N_INST-1:0] cnt_out,
  output logic [N_INST-1:0] count_done,
  output logic [7:0] count_value_8,
  output logic [7:0] count_value_9,
  output logic pulse_ramp_en
);

  // Positions of the asynchronous inputs in the synchroniser vector.
  localparam int IX_RC = 0;
  localparam int IX_LF = 1;
  localparam int IX_RING = 2;
  localparam int IX_SPI = 3;
  localparam int IX_FSM = 4;
  localparam int IX_PWM = 5;
  localparam int IX_A72 = 6;
  localparam int IX_A73 = 7;
  localparam int IX_B73 = 8;
  localparam int IX_PREV = 9;
  localparam int IX_TRIG = 10;
  localparam int N_EXT = IX_TRIG + N_INST;
  // Instances from this index upward carry the 4-bit selector.
  localparam int FIRST_WIDE = 3;
  localparam int RAMP_INST = 3;

  logic [N_EXT-1:0] ext_in, ext_lvl, ext_rise;
  ecdc_ticks_type ticks;
  logic [7:0] rc_div_r, rc_div_nxt;
  logic [2:0] route_div_r, route_div_nxt;
  ecdc_cfg_type cfg_r [N_INST];
  ecdc_cfg_type cfg_nxt [N_INST];
  logic wr_pend_r, wr_pend_nxt;
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [N_INST-1:0] route_vec, prev_vec, tick_vec, resv_vec, busy_vec;
  logic [7:0] cnt_w [N_INST];
  logic acc;

  // Every asynchronous pin input passes the synchroniser before any logic looks at it.
  assign ext_in = {trig_in, prev_count_done, route_b_sig_73, route_a_sig_73, route_a_sig_72,
                   pulse_mod_clk, state_machine_clk_div_256, spi_clk, ring_osc_clk,
                   low_freq_osc_clk, rc_osc_clk};

  ecdc_sync #(.W(N_EXT)) u_sync (
    .clock(clock),
    .rst(rst),
    .din(ext_in),
    .level(ext_lvl),
    .rise(ext_rise)
  );

  // One shared divider serves all oscillator taps, so their ticks stay phase related.
  always_comb
  begin
    rc_div_nxt = rc_div_r;
    route_div_nxt = route_div_r;
    if (ext_rise[IX_RC])
    begin
      rc_div_nxt = (rc_div_r == `ECDC_DIV_WRAP) ? 8'h00 : rc_div_r + 8'h01;
    end
    if (ext_rise[IX_A72])
    begin
      route_div_nxt = route_div_r + 3'h1;
    end
  end

  // Divider registers.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rc_div_r <= 8'h00;
      route_div_r <= 3'h0;
    end
    else
    begin
      rc_div_r <= rc_div_nxt;
      route_div_r <= route_div_nxt;
    end
  end

  // Tick pulses of the shared sources, each one block-clock cycle wide.
  assign ticks.rc = ext_rise[IX_RC];
  assign ticks.rc_d4 = ext_rise[IX_RC] && ((rc_div_r % `ECDC_DIV_A) == `ECDC_DIV_A - 8'd1);
  assign ticks.rc_d12 = ext_rise[IX_RC] && ((rc_div_r % `ECDC_DIV_B) == `ECDC_DIV_B - 8'd1);
  assign ticks.rc_d24 = ext_rise[IX_RC] && ((rc_div_r % `ECDC_DIV_C) == `ECDC_DIV_C - 8'd1);
  assign ticks.rc_d64 = ext_rise[IX_RC] && ((rc_div_r % `ECDC_DIV_D) == `ECDC_DIV_D - 8'd1);
  assign ticks.low_freq = ext_rise[IX_LF];
  assign ticks.ring = ext_rise[IX_RING];
  assign ticks.spi_clk = ext_rise[IX_SPI];
  assign ticks.fsm_d256 = ext_rise[IX_FSM];
  assign ticks.pulse_mod = ext_rise[IX_PWM];
  assign ticks.route_a72_d8 = ext_rise[IX_A72] && (route_div_r == `ECDC_ROUTE_DIV_LAST);

  // Routing signal behind the matrix code of each instance.
  assign route_vec = {ext_rise[IX_A72], ext_rise[IX_B73], ext_rise[IX_B73], ext_rise[IX_A73], ext_rise[IX_A73]};

  // Bus slave: zero wait states, address captured in the address phase.
  assign acc = hsel && htrans[1] && hready;

  always_comb
  begin
    int idx;
    idx = 0;
    for (int k = 0; k < N_INST; k++)
    begin
      cfg_nxt[k] = cfg_r[k];
    end
    wr_pend_nxt = acc && hwrite && (hsize == 3'b010);
    wr_addr_nxt = wr_pend_nxt ? haddr : wr_addr_r;
    rdata_nxt = 32'h0000_0000;
    // A write lands at the end of its data phase.
    if (wr_pend_r && (wr_addr_r[ADDR_W-1:5] == '0) && (wr_addr_r[1:0] == 2'b00))
    begin
      idx = int'(wr_addr_r[4:2]);
      if (idx < N_INST)
      begin
        cfg_nxt[idx].load = hwdata[`ECDC_LOAD_LSB +: 8];
        cfg_nxt[idx].csel = hwdata[`ECDC_CSEL_LSB +: 4];
        cfg_nxt[idx].edge_mode = hwdata[`ECDC_EDGE_LSB +: 2];
        cfg_nxt[idx].func = hwdata[`ECDC_FUNC_BIT];
        // The narrow selector has no fourth bit; it reads back as zero.
        if (idx < FIRST_WIDE)
        begin
          cfg_nxt[idx].csel[3] = 1'b0;
        end
      end
    end
    // Read data is latched in the address phase, so it stands from a flop in the data phase.
    if (acc && !hwrite)
    begin
      if ((haddr[ADDR_W-1:5] == '0) && (haddr[1:0] == 2'b00) && (int'(haddr[4:2]) < N_INST))
      begin
        rdata_nxt = {17'h0_0000, cfg_r[int'(haddr[4:2])]};
      end
      else if (haddr == `ECDC_OFF_STATUS)
      begin
        rdata_nxt = {17'h0_0000, resv_vec, busy_vec, cnt_out};
      end
      else if (haddr == `ECDC_OFF_COUNT_LO)
      begin
        rdata_nxt = {cnt_w[3], cnt_w[2], cnt_w[1], cnt_w[0]};
      end
      else if (haddr == `ECDC_OFF_COUNT_HI)
      begin
        rdata_nxt = {24'h00_0000, cnt_w[4]};
      end
    end
  end

  // Bus and configuration registers.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int k = 0; k < N_INST; k++)
      begin
        cfg_r[k] <= '{func: `ECDC_FUNC_RST, edge_mode: `ECDC_EDGE_RST, csel: `ECDC_CSEL_RST,
                      load: `ECDC_LOAD_RST};
      end
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      for (int k = 0; k < N_INST; k++)
      begin
        cfg_r[k] <= cfg_nxt[k];
      end
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // The counter/delay engines, each clocked by its selected tick.
  for (genvar i = 0; i < N_INST; i++)
  begin : g_inst
    ecdc_state_type state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic out_r, out_nxt, done_r, done_nxt, lvl_r, lvl_nxt, trig_d_r, trig;
    logic rise, fall, qual, hold_lvl;

    // The first instance chains from the counter before it, the rest from their neighbour.
    if (i == 0)
    begin : g_first
      assign prev_vec[i] = ext_rise[IX_PREV];
    end
    else
    begin : g_next
      assign prev_vec[i] = count_done[i-1];
    end

    ecdc_src_sel #(.WIDE(i >= FIRST_WIDE)) u_sel (
      .ticks(ticks),
      .prev_tick(prev_vec[i]),
      .route_tick(route_vec[i]),
      .csel(cfg_r[i].csel),
      .tick(tick_vec[i]),
      .reserved(resv_vec[i])
    );

    // Edge qualification; code 11 gives no edge in either function.
    assign trig = ext_lvl[IX_TRIG + i];
    assign rise = trig && !trig_d_r;
    assign fall = !trig && trig_d_r;
    always_comb
    begin
      case (cfg_r[i].edge_mode)
        ECDC_EDGE_BOTH: qual = rise || fall;
        ECDC_EDGE_FALL: qual = fall;
        ECDC_EDGE_RISE: qual = rise;
        default: qual = 1'b0;
      endcase
    end
    assign hold_lvl = cfg_r[i].func && (cfg_r[i].edge_mode == ECDC_EDGE_NONE) && trig;

    // Delay copies the input level after load plus one ticks; counter pulses every load plus one ticks.
    always_comb
    begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      lvl_nxt = lvl_r;
      done_nxt = 1'b0;
      case (state_r)
        ECDC_ST_IDLE:
        begin
          if (cfg_r[i].func)
          begin
            cnt_nxt = cfg_r[i].load;
            out_nxt = 1'b0;
            state_nxt = ECDC_ST_RUN;
          end
          else if (qual)
          begin
            cnt_nxt = cfg_r[i].load;
            lvl_nxt = trig;
            state_nxt = ECDC_ST_RUN;
          end
        end
        ECDC_ST_RUN:
        begin
          if (hold_lvl)
          begin
            cnt_nxt = cfg_r[i].load;
            out_nxt = 1'b0;
            state_nxt = ECDC_ST_HOLD;
          end
          else if (qual)
          begin
            // A new edge restarts a delay, or resets a counter.
            cnt_nxt = cfg_r[i].load;
            lvl_nxt = trig;
            if (cfg_r[i].func)
            begin
              out_nxt = 1'b0;
            end
          end
          else if (tick_vec[i])
          begin
            if (cnt_r == 8'h00)
            begin
              done_nxt = 1'b1;
              if (cfg_r[i].func)
              begin
                cnt_nxt = cfg_r[i].load;
                out_nxt = 1'b1;
              end
              else
              begin
                out_nxt = lvl_r;
                state_nxt = ECDC_ST_IDLE;
              end
            end
            else
            begin
              cnt_nxt = cnt_r - 8'h01;
              if (cfg_r[i].func)
              begin
                out_nxt = 1'b0;
              end
            end
          end
        end
        ECDC_ST_HOLD:
        begin
          cnt_nxt = cfg_r[i].load;
          if (!hold_lvl)
          begin
            state_nxt = ECDC_ST_RUN;
          end
        end
        default: state_nxt = ECDC_ST_IDLE;
      endcase
    end

    // Engine registers.
    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        state_r <= ECDC_ST_IDLE;
        cnt_r <= 8'h00;
        out_r <= 1'b0;
        done_r <= 1'b0;
        lvl_r <= 1'b0;
        trig_d_r <= 1'b0;
      end
      else
      begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        out_r <= out_nxt;
        done_r <= done_nxt;
        lvl_r <= lvl_nxt;
        trig_d_r <= trig;
      end
    end

    assign cnt_out[i] = out_r;
    assign count_done[i] = done_r;
    assign busy_vec[i] = (state_r != ECDC_ST_IDLE);
    assign cnt_w[i] = cnt_r;
  end

  // Values handed to the modulators, and the ramp enable of instance eight.
  assign count_value_8 = cnt_w[RAMP_INST];
  assign count_value_9 = cnt_w[N_INST-1];
  assign pulse_ramp_en = cfg_r[RAMP_INST].func;

endmodule

// ### tb/ecdc_top_properties.sv
// Checker for the counter/delay configuration block, bound into its top module.
// Assumes single whole-word transfers and a bus slave that never waits.
`timescale 1ns/1ps
module ecdc_top_properties import ecdc_pkg::*; #(
  parameter int N_INST = 5,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Bus signals.
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Instance outputs.
  input wire logic [N_INST-1:0] cnt_out,
  input wire logic [N_INST-1:0] count_done,
  input wire logic [7:0] count_value_8,
  input wire logic [7:0] count_value_9,
  input wire logic pulse_ramp_en
);
  logic take;
  logic rd_r;
  logic rd_nxt;
  logic wr_r;
  logic wr_nxt;
  logic [ADDR_W-1:0] adr_r;
  logic [ADDR_W-1:0] adr_nxt;
  logic [N_INST-1:0] func_r;
  logic [N_INST-1:0] func_nxt;
  logic [3:0] csel9_r;
  logic [3:0] csel9_nxt;

  // A transfer is taken only when selected, active and ready.
  assign take = hsel && htrans[1] && hready;

  // Shadow the function bits and the clock code of instance nine, since modes are not visible at the ports.
  always_comb
  begin
    rd_nxt = take && !hwrite;
    wr_nxt = take && hwrite && hsize == 3'h2;
    adr_nxt = take ? haddr : adr_r;
    func_nxt = func_r;
    csel9_nxt = csel9_r;
    if (wr_r && adr_r < 8'h14 && adr_r[1:0] == 2'h0)
      func_nxt[adr_r[4:2]] = hwdata[14];
    if (wr_r && adr_r == 8'h10)
      csel9_nxt = hwdata[11:8];
  end

  // Register the shadow state.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      adr_r <= '0;
      func_r <= '0;
      csel9_r <= 4'h0;
    end
    else
    begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      adr_r <= adr_nxt;
      func_r <= func_nxt;
      csel9_r <= csel9_nxt;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ready_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  reset_clear_a: assert property ($fell(rst) |-> cnt_out == '0 && count_done == '0 && count_value_8 == 8'h00
    && count_value_9 == 8'h00 && !pulse_ramp_en) else $error("outputs not cleared by reset");
  bus_idle_a: assert property (!rd_r |-> hrdata == 32'h0) else $error("read data outside a read");
  cfg_upper_a: assert property (rd_r && adr_r < 8'h14 && adr_r[1:0] == 2'h0 |-> hrdata[31:15] == 17'h0)
    else $error("config word has upper bits set");
  narrow_sel_a: assert property (rd_r && adr_r < 8'h0c && adr_r[1:0] == 2'h0 |-> !hrdata[11])
    else $error("narrow clock code wider than three bits");
  ramp_follow_a: assert property (wr_r && adr_r == 8'h0c |=> ##[0:1] pulse_ramp_en == func_r[3])
    else $error("ramp enable does not follow function bit");
  done_pulse_a: assert property (count_done[0] |=> !count_done[0]) else $error("done longer than one cycle");
  counter_out_a: assert property (|(count_done & func_r) |-> (count_done & func_r & ~cnt_out) == '0)
    else $error("counter expired without output high");
  reserved_hold_a: assert property (csel9_r >= 4'hd && $past(csel9_r) >= 4'hd |-> $stable(count_value_9))
    else $error("count moved on a reserved clock code");

  // Main scenarios reached.
  cover property (count_done[1]);
  cover property (rd_r && adr_r == 8'h14 && hrdata[14]);
  cover property (wr_r && adr_r == 8'h0c ##2 pulse_ramp_en);
endmodule

bind ecdc_top ecdc_top_properties #(.N_INST(N_INST), .ADDR_W(ADDR_W)) u_props (.clock(clock), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cnt_out(cnt_out),
  .count_done(count_done), .count_value_8(count_value_8), .count_value_9(count_value_9),
  .pulse_ramp_en(pulse_ramp_en));

// ### tb/test_ecdc_top.sv
// Self-checking bench for the counter/delay configuration block.
// Assumes the checker is bound separately; rc_osc_clk is driven by rc_tick, all other sources toggle at random.
`timescale 1ns/1ps
module test_ecdc_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rc_osc_clk = 1'b0;
  logic [8:0] misc_src = 9'h0;
  logic [4:0] trig_in = 5'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [4:0] cnt_out;
  logic [4:0] count_done;
  logic [7:0] count_value_8;
  logic [7:0] count_value_9;
  logic pulse_ramp_en;
  logic rd_pend = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [7:0] zero_a [5] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h02};

  ecdc_top u_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rc_osc_clk(rc_osc_clk), .low_freq_osc_clk(misc_src[0]), .ring_osc_clk(misc_src[1]), .spi_clk(misc_src[2]),
    .state_machine_clk_div_256(misc_src[3]), .pulse_mod_clk(misc_src[4]), .route_a_sig_72(misc_src[5]),
    .route_a_sig_73(misc_src[6]), .route_b_sig_73(misc_src[7]), .prev_count_done(misc_src[8]),
    .trig_in(trig_in), .cnt_out(cnt_out), .count_done(count_done), .count_value_8(count_value_8),
    .count_value_9(count_value_9), .pulse_ramp_en(pulse_ramp_en));

  // Half-period toggle for a 50 ns clock.
  always #25 clock = ~clock;

  // Unselected sources still toggle, so a wrong mux choice disturbs the counts.
  always @(posedge clock)
    misc_src <= 9'($urandom);

  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge; a hang ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
  endtask

  // The expectation is queued before the read so the monitor finds it in order.
  task automatic bus_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    bus_xfer(1'b0, a, 32'h0);
  endtask

  // A run of n rising edges on the oscillator pin, each held long enough to pass the synchroniser.
  task automatic rc_tick(input int n);
    repeat (n)
    begin
      rc_osc_clk <= 1'b1;
      repeat (4) @(posedge clock);
      rc_osc_clk <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask

  // Compare each read data phase with the oldest queued expectation.
  always @(posedge clock)
  begin
    if (rd_pend)
      check(hrdata & mask_q.pop_front(), exp_q.pop_front());
    rd_pend <= !rst && hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial
  begin
    logic [31:0] d;
    logic st;
    void'($urandom(32'h9ef2));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    // Reset values, read-only words, an unmapped and an unaligned address.
    for (int i = 0; i < 5; i++)
      bus_read(8'(4 * i), 32'h0000_00ff, 32'hffff_ffff);
    foreach (zero_a[i])
      bus_read(zero_a[i], 32'h0, 32'hffff_ffff);
    // Every code of both selectors; nine counts from code 12 on, so a reserved code must freeze it.
    for (int c = 0; c < 16; c++)
    begin
      d = {17'h0, (c >= 12), 2'h3, 4'(c), 8'($urandom)};
      bus_xfer(1'b1, 8'h10, d);
      bus_read(8'h10, d, 32'hffff_ffff);
      bus_read(8'h14, (c >= 13) ? 32'h4000 : 32'h0, 32'h4000);
      if (c < 8)
      begin
        d = $urandom & 32'hffff_bfff;
        d[10:8] = 3'(c);
        bus_xfer(1'b1, 8'h00, d);
        bus_read(8'h00, d & 32'h0000_37ff, 32'hffff_ffff);
      end
    end
    // Nine leaves the reserved code and is held at its load by a high reset input.
    bus_xfer(1'b1, 8'h10, 32'h0000_7000);
    trig_in[4] <= 1'b1;
    // Counter chain: five counts the oscillator, six counts five's expiries.
    bus_xfer(1'b1, 8'h04, 32'h0000_4500);
    bus_xfer(1'b1, 8'h0c, 32'h0000_4005);
    bus_xfer(1'b1, 8'h00, 32'h0000_4003);
    repeat (4) @(posedge clock);
    bus_read(8'h18, 32'h0500_0003, 32'hffff_ffff);
    rc_tick(3);
    bus_read(8'h18, 32'h0200_0000, 32'hffff_ffff);
    rc_tick(1);
    bus_read(8'h18, 32'h0100_0003, 32'hffff_ffff);
    bus_read(8'h14, 32'h0000_0363, 32'h0000_03ff);
    // Level hold: count stays at its load while the reset input is high.
    bus_xfer(1'b1, 8'h00, 32'h0000_7003);
    trig_in[0] <= 1'b1;
    repeat (4) @(posedge clock);
    rc_tick(2);
    bus_read(8'h18, 32'h3, 32'hff);
    bus_read(8'h14, 32'h0, 32'h1);
    trig_in[0] <= 1'b0;
    repeat (4) @(posedge clock);
    rc_tick(1);
    bus_read(8'h18, 32'h2, 32'hff);
    // Delay on seven for each edge code, with a rise and then a fall.
    for (int e = 0; e < 4; e++)
    begin
      bus_xfer(1'b1, 8'h08, {18'h0, 2'(e), 4'h0, 8'h01});
      trig_in[2] <= 1'b1;
      repeat (4) @(posedge clock);
      st = (e == 0 || e == 2);
      bus_read(8'h14, {24'h0, st, 7'h0}, 32'h80);
      rc_tick(2);
      bus_read(8'h14, {29'h0, st, 2'h0}, st ? 32'h84 : 32'h80);
      trig_in[2] <= 1'b0;
      repeat (4) @(posedge clock);
      st = (e == 0 || e == 1);
      bus_read(8'h14, {24'h0, st, 7'h0}, 32'h80);
      rc_tick(2);
      bus_read(8'h14, 32'h0, st ? 32'h84 : 32'h80);
    end
    repeat (2) @(posedge clock);
    complete_run();
  end
endmodule
